/* shared/power_mode_pkg.sv */
// constants and types for the power mode controller
package power_mode_pkg;
  localparam int unsigned NUM_PINS   = 8;
  localparam int unsigned SYNC_DEPTH = 2;
  // fast clock settle time after restart, in ns
  localparam int unsigned FAST_SETTLE_NS     = 100;
  localparam int unsigned CLK_PERIOD_NS      = 5;
  localparam int unsigned FAST_SETTLE_CYCLES =
    (FAST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_LOAD = 8'(FAST_SETTLE_CYCLES - 1);
  localparam logic [7:0] SETTLE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    MODE_ACTIVE     = 3'b000,
    MODE_IDLE       = 3'b001,
    MODE_STBY_ENTER = 3'b010,
    MODE_STANDBY    = 3'b011,
    MODE_STBY_WAKE  = 3'b100,
    MODE_SHUTDOWN   = 3'b101,
    MODE_HELD       = 3'b110
  } mode_t;

  typedef enum logic [1:0] {
    REQ_NONE     = 2'b00,
    REQ_IDLE     = 2'b01,
    REQ_STANDBY  = 2'b10,
    REQ_SHUTDOWN = 2'b11
  } req_t;

  typedef enum logic [1:0] {
    CAUSE_POWER_ON = 2'b00,
    CAUSE_RESET_PIN = 2'b01,
    CAUSE_PIN_WAKE = 2'b10
  } cause_t;
endpackage

/* rtl/power_mode_controller.sv */
// power mode sequencer: modes, clock and domain gating, wake, pin latch, reset cause
// Behaviour
// - active: processor clocked, enabled peripherals run normally
// - idle: processor core and memory clock stopped, peripherals may run
// - any interrupt in idle returns to active
// - standby: only the always-on and sensor domains stay powered
// - standby exits only on external wake, clock event or sensor event
// - standby wake resumes processor in place, retained peripherals keep setup
// - all I/O pins held latched during standby
// - shutdown: everything off, I/O pins held at pre-entry value
// - level change on a shutdown wake pin wakes device as reset
// - reset cause recorded: pin wake, reset pin, or power-on
// - across shutdown only latched I/O and flash survive
// - fast clock runs in active and idle, stops in standby and shutdown
// - medium clock runs active and idle, optional standby, off in shutdown
// - slow clock runs except in shutdown and held reset
// - retention full active/idle, partial standby, none shutdown or held reset
// - reset pin honoured in every mode
`timescale 1ns/1ps
module power_mode_controller (
  input  wire logic                                ref_clk,
  input  wire logic                                rstn,
  input  wire power_mode_pkg::req_t                modeReq,
  input  wire logic                                medClkInStandby,
  input  wire logic                                irqAny,
  input  wire logic                                extWake,
  input  wire logic                                rtcEvent,
  input  wire logic                                sensorEvent,
  input  wire logic                                resetPinN,
  input  wire logic [power_mode_pkg::NUM_PINS-1:0] wakePinEn,
  input  wire logic [power_mode_pkg::NUM_PINS-1:0] pinIn,
  input  wire logic                                fastClkReady,
  output logic                                     cpuClkEn,
  output logic                                     memClkEn,
  output logic                                     periphClkEn,
  output logic                                     periphPowerEn,
  output logic                                     alwaysOnPowerEn,
  output logic                                     sensorPowerEn,
  output logic                                     mainFastClockEn,
  output logic                                     mediumSpeedClockEn,
  output logic                                     slowSystemClockEn,
  output logic                                     ioLatchEn,
  output logic [power_mode_pkg::NUM_PINS-1:0]      ioLatchVal,
  output logic                                     regRetainFull,
  output logic                                     regRetainPartial,
  output logic                                     sramRetain,
  output logic                                     sysResetReq,
  output power_mode_pkg::cause_t                   resetCause,
  output power_mode_pkg::mode_t                    modeNow
);
  import power_mode_pkg::*;

  // two-stage synchronisers; first stage feeds only the second
  logic [3:0] wakeMeta_q, wakeSync_q, wakeMeta_d, wakeSync_d;
  logic       rstPinMeta_q, rstPinSync_q;
  logic [NUM_PINS-1:0] pinMeta_q, pinSync_q;

  always_comb begin
    wakeMeta_d = {irqAny, extWake, rtcEvent, sensorEvent};
    wakeSync_d = wakeMeta_q;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wakeMeta_q   <= 4'h0;
      wakeSync_q   <= 4'h0;
      rstPinMeta_q <= 1'b0;
      rstPinSync_q <= 1'b0;
      pinMeta_q    <= '0;
      pinSync_q    <= '0;
    end else begin
      wakeMeta_q   <= wakeMeta_d;
      wakeSync_q   <= wakeSync_d;
      rstPinMeta_q <= ~resetPinN;
      rstPinSync_q <= rstPinMeta_q;
      pinMeta_q    <= pinIn;
      pinSync_q    <= pinMeta_q;
    end
  end

  logic irqS, extS, rtcS, sensS;
  assign {irqS, extS, rtcS, sensS} = wakeSync_q;

  // sequencer state
  mode_t               mode_q, mode_d;
  logic [7:0]          settle_q, settle_d;
  logic [NUM_PINS-1:0] latch_q, latch_d;
  logic                latchEn_q, latchEn_d;
  cause_t              cause_q, cause_d;
  logic                rstReq_q, rstReq_d;

  always_comb begin
    mode_d    = mode_q;
    settle_d  = settle_q;
    latch_d   = latch_q;
    latchEn_d = latchEn_q;
    cause_d   = cause_q;
    rstReq_d  = 1'b0;
    if (rstPinSync_q) begin
      // reset pin wins in any mode, shutdown included
      mode_d    = MODE_HELD;
      cause_d   = CAUSE_RESET_PIN;
      latchEn_d = 1'b0;
    end else begin
      case (mode_q)
        MODE_HELD: begin
          mode_d   = MODE_ACTIVE;
          rstReq_d = 1'b1;
        end
        MODE_ACTIVE: begin
          case (modeReq)
            REQ_IDLE: mode_d = MODE_IDLE;
            REQ_STANDBY, REQ_SHUTDOWN: begin
              // pins captured one cycle before domains drop for standby, in the same cycle for shutdown
              latch_d   = pinSync_q;
              latchEn_d = 1'b1;
              mode_d    = (modeReq == REQ_SHUTDOWN) ? MODE_SHUTDOWN : MODE_STBY_ENTER;
            end
            default: mode_d = MODE_ACTIVE;
          endcase
        end
        MODE_IDLE: begin
          if (irqS) mode_d = MODE_ACTIVE;
        end
        MODE_STBY_ENTER: mode_d = MODE_STANDBY;
        MODE_STANDBY: begin
          if (extS || rtcS || sensS) begin
            mode_d   = MODE_STBY_WAKE;
            settle_d = SETTLE_LOAD;
          end
        end
        MODE_STBY_WAKE: begin
          // processor stays gated until fast clock is settled
          if (settle_q != SETTLE_ZERO) settle_d = settle_q - 8'h01;
          else if (fastClkReady) begin
            mode_d    = MODE_ACTIVE;
            latchEn_d = 1'b0;
          end
        end
        MODE_SHUTDOWN: begin
          if (|(wakePinEn & (pinSync_q ^ latch_q))) begin
            mode_d    = MODE_ACTIVE;
            cause_d   = CAUSE_PIN_WAKE;
            rstReq_d  = 1'b1;
            latchEn_d = 1'b0;
          end
        end
        default: mode_d = MODE_HELD;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q    <= MODE_HELD;
      settle_q  <= SETTLE_ZERO;
      latch_q   <= '0;
      latchEn_q <= 1'b0;
      cause_q   <= CAUSE_POWER_ON;
      rstReq_q  <= 1'b1;
    end else begin
      mode_q    <= mode_d;
      settle_q  <= settle_d;
      latch_q   <= latch_d;
      latchEn_q <= latchEn_d;
      cause_q   <= cause_d;
      rstReq_q  <= rstReq_d;
    end
  end

  // mode decode; the wake state already powers domains but holds the processor
  logic isAct, isIdle, isStby, isWake, isShut;
  always_comb begin
    isAct  = (mode_q == MODE_ACTIVE);
    isIdle = (mode_q == MODE_IDLE);
    isStby = (mode_q == MODE_STANDBY) || (mode_q == MODE_STBY_ENTER);
    isWake = (mode_q == MODE_STBY_WAKE);
    isShut = (mode_q == MODE_SHUTDOWN);
  end

  always_comb begin
    cpuClkEn           = isAct;
    memClkEn           = isAct;
    periphClkEn        = isAct || isIdle;
    periphPowerEn      = isAct || isIdle || isWake || (mode_q == MODE_STBY_ENTER);
    alwaysOnPowerEn    = !isShut && (mode_q != MODE_HELD);
    sensorPowerEn      = alwaysOnPowerEn;
    mainFastClockEn    = isAct || isIdle || isWake;
    mediumSpeedClockEn = isAct || isIdle || isWake || (isStby && medClkInStandby);
    slowSystemClockEn  = alwaysOnPowerEn;
    regRetainFull      = isAct || isIdle;
    regRetainPartial   = isStby || isWake;
    sramRetain         = isAct || isIdle || isStby || isWake;
    ioLatchEn          = latchEn_q;
    ioLatchVal         = latch_q;
    sysResetReq        = rstReq_q;
    resetCause         = cause_q;
    modeNow            = mode_q;
  end

  // settle counter for the checks only; saturates so a stuck oscillator cannot wrap it
  logic [7:0] wakeCnt_q, wakeCnt_d;
  always_comb begin
    wakeCnt_d = isWake ? wakeCnt_q : SETTLE_ZERO;
    if (isWake && !(&wakeCnt_q)) wakeCnt_d = wakeCnt_q + 8'h01;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) wakeCnt_q <= SETTLE_ZERO;
    else wakeCnt_q <= wakeCnt_d;
  end

  // checks
  a_idle_wakes: assert property (@(posedge ref_clk) disable iff (!rstn)
    (mode_q == MODE_IDLE && irqS && !rstPinSync_q) |=> (mode_q == MODE_ACTIVE))
    else $error("idle did not return to active on interrupt");

  a_idle_stays: assert property (@(posedge ref_clk) disable iff (!rstn)
    (mode_q == MODE_IDLE && !irqS && !rstPinSync_q) |=> (mode_q == MODE_IDLE))
    else $error("idle left without an interrupt");

  a_stby_stays: assert property (@(posedge ref_clk) disable iff (!rstn)
    (mode_q == MODE_STANDBY && !extS && !rtcS && !sensS && !rstPinSync_q)
      |=> (mode_q == MODE_STANDBY))
    else $error("standby left without a wake source");

  a_fast_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    (isStby || isShut) |-> !mainFastClockEn && !cpuClkEn)
    else $error("fast clock running in low power mode");

  a_latch_held: assert property (@(posedge ref_clk) disable iff (!rstn)
    (isStby || isShut) |-> ioLatchEn && (!$past(isStby || isShut) || $stable(ioLatchVal)))
    else $error("pins not held latched");

  sequence s_wakeDone;
    (mode_q == MODE_STBY_WAKE) ##1 (mode_q == MODE_ACTIVE);
  endsequence
  sequence s_shutExit;
    (mode_q == MODE_SHUTDOWN) ##1 (mode_q == MODE_ACTIVE);
  endsequence
  sequence s_stbyEntry;
    (mode_q == MODE_ACTIVE) ##1 (mode_q == MODE_STBY_ENTER);
  endsequence

  a_settle_first: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_wakeDone |-> wakeCnt_q >= 8'(FAST_SETTLE_CYCLES))
    else $error("processor released before clock settle");

  a_fast_wake: assert property (@(posedge ref_clk) disable iff (!rstn)
    isWake |-> mainFastClockEn && periphPowerEn && !cpuClkEn)
    else $error("wake state gating wrong");

  a_wake_resume: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_wakeDone |-> !sysResetReq && regRetainFull && !ioLatchEn)
    else $error("standby wake did not resume in place");

  a_shut_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_shutExit |-> sysResetReq && !ioLatchEn)
    else $error("shutdown exit without reset");

  a_latch_first: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_stbyEntry |-> ioLatchEn && periphPowerEn)
    else $error("pins not latched before power removal");

  a_active_runs: assert property (@(posedge ref_clk) disable iff (!rstn)
    isAct |-> cpuClkEn && memClkEn && periphClkEn && periphPowerEn && mainFastClockEn)
    else $error("active gating wrong");

  a_held_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    (mode_q == MODE_HELD) |-> !cpuClkEn && !regRetainFull && !regRetainPartial && !sramRetain)
    else $error("state retained while held in reset");

  a_slow_runs: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!isShut && mode_q != MODE_HELD) |-> slowSystemClockEn && alwaysOnPowerEn)
    else $error("slow clock stopped outside shutdown");

  a_stby_domains: assert property (@(posedge ref_clk) disable iff (!rstn)
    (mode_q == MODE_STANDBY) |-> !periphPowerEn && !periphClkEn && sensorPowerEn && sramRetain)
    else $error("standby domain gating wrong");

  a_med_shut: assert property (@(posedge ref_clk) disable iff (!rstn)
    isShut |-> !mediumSpeedClockEn && !sensorPowerEn)
    else $error("medium clock running in shutdown");

  a_shut_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    isShut |-> !alwaysOnPowerEn && !slowSystemClockEn && !sramRetain)
    else $error("domain powered in shutdown");

  a_pin_wake: assert property (@(posedge ref_clk) disable iff (!rstn)
    (isShut && |(wakePinEn & (pinSync_q ^ latch_q)) && !rstPinSync_q)
      |=> sysResetReq && resetCause == CAUSE_PIN_WAKE)
    else $error("shutdown pin wake missed");

  a_cause_kept: assert property (@(posedge ref_clk) disable iff (!rstn)
    $changed(resetCause) |-> $past(rstPinSync_q) || $past(isShut))
    else $error("reset cause changed without a reset");

  a_reset_pin: assert property (@(posedge ref_clk) disable iff (!rstn)
    rstPinSync_q |=> (mode_q == MODE_HELD) && resetCause == CAUSE_RESET_PIN)
    else $error("reset pin not honoured");

  a_idle_gates: assert property (@(posedge ref_clk) disable iff (!rstn)
    isIdle |-> !cpuClkEn && !memClkEn && periphClkEn)
    else $error("idle gating wrong");
endmodule // power_mode_controller

/* dv/fast_osc_model.sv */
// fast oscillator model: reports stable a while after its enable rises
`timescale 1ns/1ps
module fast_osc_model (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic enable,
  input  wire logic slowStart,
  output logic      ready
);
  logic [5:0] count_q;
  logic [5:0] count_d;
  // drops one cycle after enable falls, so a stale ready never leaks into the next wake
  assign ready = count_q >= (slowStart ? 6'h28 : 6'h02);
  always_comb begin
    count_d = !enable ? 6'h00 : (ready ? count_q : count_q + 6'h01);
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) count_q <= 6'h00;
    else count_q <= count_d;
  end
endmodule // fast_osc_model

/* dv/power_mode_controller_tb.sv */
// self-checking testbench for the power mode controller
`timescale 1ns/1ps
module power_mode_controller_tb;
  import power_mode_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  req_t modeReq = REQ_NONE;
  logic medClkInStandby = 1'b0, irqAny = 1'b0, extWake = 1'b0, rtcEvent = 1'b0;
  logic sensorEvent = 1'b0, resetPinN = 1'b1, slowOsc = 1'b0;
  logic [NUM_PINS-1:0] wakePinEn = '0, pinIn = '0, held, ioLatchVal;
  logic fastClkReady, cpuClkEn, memClkEn, periphClkEn, periphPowerEn, alwaysOnPowerEn;
  logic sensorPowerEn, mainFastClockEn, mediumSpeedClockEn, slowSystemClockEn, ioLatchEn;
  logic regRetainFull, regRetainPartial, sramRetain, sysResetReq;
  cause_t resetCause;
  mode_t modeNow, lastMode = MODE_HELD, m;
  mode_t expQ[$];
  int errors = 0, comparisons = 0, cnt;
  logic pulse;

  always #2.5 ref_clk = ~ref_clk;

  power_mode_controller DUT (.ref_clk, .rstn, .modeReq, .medClkInStandby, .irqAny, .extWake,
    .rtcEvent, .sensorEvent, .resetPinN, .wakePinEn, .pinIn, .fastClkReady, .cpuClkEn,
    .memClkEn, .periphClkEn, .periphPowerEn, .alwaysOnPowerEn, .sensorPowerEn,
    .mainFastClockEn, .mediumSpeedClockEn, .slowSystemClockEn, .ioLatchEn, .ioLatchVal,
    .regRetainFull, .regRetainPartial, .sramRetain, .sysResetReq, .resetCause, .modeNow);

  fast_osc_model osc (.ref_clk, .rstn, .enable(mainFastClockEn), .slowStart(slowOsc),
    .ready(fastClkReady));

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic waitMode(mode_t want, output int n);
    n = 0;
    while (modeNow !== want && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 300) check("mode wait", 8'(want), 8'(modeNow));
  endtask

  // watcher: every mode change takes the oldest note and checks gating of steady modes
  always @(negedge ref_clk) begin
    if (rstn && modeNow !== lastMode) begin
      m = (expQ.size() == 0) ? lastMode : expQ.pop_front();
      check("mode", 8'(m), 8'(modeNow));
      pulse = (m == MODE_ACTIVE) && (lastMode inside {MODE_HELD, MODE_SHUTDOWN});
      check("reset pulse", 8'(pulse), 8'(sysResetReq));
      lastMode = modeNow;
      if (m inside {MODE_ACTIVE, MODE_IDLE, MODE_STANDBY, MODE_SHUTDOWN}) begin
        check("gating", {m == MODE_ACTIVE, m == MODE_ACTIVE, m inside {MODE_ACTIVE, MODE_IDLE},
          m inside {MODE_ACTIVE, MODE_IDLE} || (m == MODE_STANDBY && medClkInStandby),
          m != MODE_SHUTDOWN, m inside {MODE_ACTIVE, MODE_IDLE}, m == MODE_STANDBY,
          m inside {MODE_ACTIVE, MODE_IDLE}}, {cpuClkEn, memClkEn, mainFastClockEn,
          mediumSpeedClockEn, slowSystemClockEn, regRetainFull, regRetainPartial,
          periphPowerEn});
        check("domains", 8'({m inside {MODE_ACTIVE, MODE_IDLE}, m != MODE_SHUTDOWN,
          m != MODE_SHUTDOWN, m != MODE_SHUTDOWN}), 8'({periphClkEn, alwaysOnPowerEn,
          sensorPowerEn, sramRetain}));
      end
    end
  end

  initial begin
    #200000;
    errors++;
    finish_test();
  end

  initial begin
    void'($urandom(32));
    expQ.push_back(MODE_ACTIVE);
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    waitMode(MODE_ACTIVE, cnt);
    check("cause", 8'(CAUSE_POWER_ON), 8'(resetCause));
    // idle: external wake is ignored, an interrupt returns to active
    expQ.push_back(MODE_IDLE);
    expQ.push_back(MODE_ACTIVE);
    modeReq = REQ_IDLE;
    waitMode(MODE_IDLE, cnt);
    modeReq = REQ_NONE;
    extWake = 1'b1;
    repeat (6) @(negedge ref_clk);
    extWake = 1'b0;
    irqAny = 1'b1;
    waitMode(MODE_ACTIVE, cnt);
    irqAny = 1'b0;
    $display("test idle done");
    // standby left through each wake source in turn, oscillator fast and slow
    for (int s = 0; s < 3; s++) begin
      pinIn = 8'($urandom);
      medClkInStandby = s[0];
      slowOsc = s[1];
      repeat (4) @(negedge ref_clk);
      held = pinIn;
      expQ = '{MODE_STBY_ENTER, MODE_STANDBY, MODE_STBY_WAKE, MODE_ACTIVE};
      modeReq = REQ_STANDBY;
      waitMode(MODE_STANDBY, cnt);
      modeReq = REQ_NONE;
      pinIn = ~pinIn;
      irqAny = 1'b1;
      repeat (6) @(negedge ref_clk);
      check("standby stays", 8'(MODE_STANDBY), 8'(modeNow));
      check("pins held", held, ioLatchVal);
      irqAny = 1'b0;
      {sensorEvent, rtcEvent, extWake} = 3'(1 << s);
      waitMode(MODE_STBY_WAKE, cnt);
      {sensorEvent, rtcEvent, extWake} = 3'b000;
      waitMode(MODE_ACTIVE, cnt);
      check("settle", 8'h01, 8'(cnt >= FAST_SETTLE_CYCLES));
      check("latch off", 8'h00, 8'(ioLatchEn));
    end
    $display("test standby done");
    // shutdown: disabled pins may move, an enabled pin wakes as a reset
    pinIn = 8'($urandom);
    wakePinEn = 8'($urandom) | 8'h01;
    repeat (4) @(negedge ref_clk);
    held = pinIn;
    expQ = '{MODE_SHUTDOWN, MODE_ACTIVE};
    modeReq = REQ_SHUTDOWN;
    waitMode(MODE_SHUTDOWN, cnt);
    modeReq = REQ_NONE;
    pinIn = pinIn ^ ~wakePinEn;
    repeat (6) @(negedge ref_clk);
    check("shutdown stays", 8'(MODE_SHUTDOWN), 8'(modeNow));
    check("pins kept", held, ioLatchVal);
    pinIn[0] = ~pinIn[0];
    waitMode(MODE_ACTIVE, cnt);
    check("cause", 8'(CAUSE_PIN_WAKE), 8'(resetCause));
    $display("test shutdown done");
    // reset pin taken even from shutdown
    expQ.push_back(MODE_SHUTDOWN);
    expQ.push_back(MODE_HELD);
    expQ.push_back(MODE_ACTIVE);
    modeReq = REQ_SHUTDOWN;
    waitMode(MODE_SHUTDOWN, cnt);
    modeReq = REQ_NONE;
    resetPinN = 1'b0;
    waitMode(MODE_HELD, cnt);
    check("held cpu", 8'h00, 8'(cpuClkEn | regRetainFull));
    repeat (3) @(negedge ref_clk);
    resetPinN = 1'b1;
    waitMode(MODE_ACTIVE, cnt);
    check("cause", 8'(CAUSE_RESET_PIN), 8'(resetCause));
    $display("test reset pin done");
    finish_test();
  end
endmodule // power_mode_controller_tb
